/* File: rtl/acz_pkg.sv */
// Purpose: shared constants and types of the accumulator logic and zero-load datapath
// Assumes: 16-bit data words, 32-bit accumulator and product register
// Notes:   operation codes are one-hot
package acz_pkg;
    localparam int DW = 16;
    localparam int AW = 32;
    localparam int SHW = 4;
    localparam int RND_BIT = 15;
    localparam logic [AW-1:0] ACC_RST = 32'h0000_0000;
    localparam logic [AW-1:0] PRD_RST = 32'h0000_0000;
    localparam logic [AW-1:0] RND_HALF = 32'h0000_8000;
    localparam logic [DW-1:0] MEM_RST = 16'h0000;

    typedef enum logic [9:0] {
        ACZ_OP_NONE     = 10'h001,
        ACZ_OP_XOR      = 10'h002,
        ACZ_OP_XOR_SEC  = 10'h004,
        ACZ_OP_XOR_MEM  = 10'h008,
        ACZ_OP_CLR_ACC  = 10'h010,
        ACZ_OP_ZLH      = 10'h020,
        ACZ_OP_ZLH_RND  = 10'h040,
        ACZ_OP_ZHL_U    = 10'h080,
        ACZ_OP_CLR_BOTH = 10'h100,
        ACZ_OP_CLR_PRD  = 10'h200
    } acz_op_e;
endpackage

/* File: rtl/acz_opnd_if.sv */
// Purpose: operand path between the datapath top and its shifter
// Assumes: single core clock
// Notes:   combinational carrier only
`timescale 1ns/1ps
interface acz_opnd_if;
    import acz_pkg::*;
    logic [DW-1:0]  value;
    logic [SHW-1:0] shift;
    logic [AW-1:0]  shifted;
    modport src (output value, output shift, input shifted);
    modport sft (input value, input shift, output shifted);
endinterface

/* File: rtl/acz_shifter.sv */
// Purpose: zero-filled left shift of a 16-bit operand into 32 bits
// Assumes: shift count 0 to 15
// Notes:   no sign extension anywhere
`timescale 1ns/1ps
module acz_shifter
    import acz_pkg::*;
(
    acz_opnd_if.sft op
);
    // bits below and above the shifted word are zero
    always_comb
    begin
        op.shifted = {{(AW-DW){1'b0}}, op.value} << op.shift;
    end
endmodule

/* File: rtl/acz_datapath.sv */
// Purpose: accumulator logic operations and zero-load instructions
// Assumes: decoder presents one operation per cycle with its operands
// Notes:   results appear the cycle after the operation is issued
`timescale 1ns/1ps
module acz_datapath
(
    input  wire logic             SYS_CLK,
    input  wire logic             RST_N,
    input  wire acz_pkg::acz_op_e OP,
    input  wire logic             OP_VALID,
    input  wire logic [15:0]      MEM_DATA,
    input  wire logic [15:0]      IMM_DATA,
    input  wire logic             USE_IMM,
    input  wire logic [3:0]       SHIFT,
    input  wire logic [15:0]      BIT_MASK,
    input  wire logic [31:0]      SEC_ACC,
    input  wire logic             PRD_LOAD,
    input  wire logic [31:0]      PRD_IN,
    output logic      [31:0]      ACC,
    output logic      [31:0]      PRD,
    output logic      [15:0]      MEM_WDATA,
    output logic                  MEM_WE
);
    import acz_pkg::*;

    // ==========================================================
    // operand shifter
    acz_opnd_if opnd ();
    logic [AW-1:0] acc_d;
    logic [AW-1:0] prd_d;
    logic          is_op;
    logic          op_mem_xor;
    logic          op_prd_clr;

    assign opnd.value = USE_IMM ? IMM_DATA : MEM_DATA;
    assign opnd.shift = SHIFT;
    assign is_op      = OP_VALID;
    assign op_mem_xor = is_op && (OP == ACZ_OP_XOR_MEM);
    // either clear form wins over a product load in the same cycle
    assign op_prd_clr = is_op && (OP == ACZ_OP_CLR_BOTH || OP == ACZ_OP_CLR_PRD);

    acz_shifter u_shift
    (
        .op (opnd.sft)
    );

    // ==========================================================
    // accumulator next value
    always_comb
    begin
        acc_d = ACC;
        if (is_op)
        begin
            case (OP)
                ACZ_OP_XOR:      acc_d = ACC ^ opnd.shifted;
                ACZ_OP_XOR_SEC:  acc_d = ACC ^ SEC_ACC;
                ACZ_OP_CLR_ACC:  acc_d = ACC_RST;
                ACZ_OP_ZLH:      acc_d = {MEM_DATA, 16'h0000};
                ACZ_OP_ZLH_RND:  acc_d = {MEM_DATA, 16'h0000} | RND_HALF;
                ACZ_OP_ZHL_U:    acc_d = {16'h0000, MEM_DATA};
                ACZ_OP_CLR_BOTH: acc_d = ACC_RST;
                default:         acc_d = ACC;
            endcase
        end
    end

    always_comb
    begin
        prd_d = PRD_LOAD ? PRD_IN : PRD;
        if (op_prd_clr)
        begin
            prd_d = PRD_RST;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            ACC <= ACC_RST;
        else
            ACC <= acc_d;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            PRD <= PRD_RST;
        else
            PRD <= prd_d;
    end

    // memory write-back of the mask exclusive-OR
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            MEM_WDATA <= MEM_RST;
            MEM_WE    <= 1'b0;
        end
        else
        begin
            MEM_WE    <= op_mem_xor;
            MEM_WDATA <= MEM_DATA ^ (USE_IMM ? IMM_DATA : BIT_MASK);
        end
    end

    // ==========================================================
    // assertions
    sequence s_issue(acz_op_e o);
        OP_VALID && OP == o;
    endsequence

    a_xor_shift_acc: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_XOR) |=> ACC == ($past(ACC) ^ ({16'h0000, $past(opnd.value)}
            << $past(SHIFT))))
        else $error("xor result wrong");
    a_xor_low_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_XOR) |=> ((ACC ^ $past(ACC))
            & ~(32'h0000_FFFF << $past(SHIFT))) == 32'h0000_0000)
        else $error("bits outside shifted operand changed");
    a_xor_sec_acc: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_XOR_SEC) |=> ACC == ($past(ACC) ^ $past(SEC_ACC)))
        else $error("secondary xor wrong");
    a_mem_xor_wb: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_XOR_MEM) |=> MEM_WE && $stable(ACC)
            && MEM_WDATA == ($past(MEM_DATA) ^ ($past(USE_IMM) ? $past(IMM_DATA)
            : $past(BIT_MASK))))
        else $error("mask write-back wrong");
    a_clear_acc: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_CLR_ACC) |=> ACC == 32'h0000_0000)
        else $error("accumulator not cleared");
    a_zero_low_high: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_ZLH) |=> ACC == {$past(MEM_DATA), 16'h0000})
        else $error("load high wrong");
    a_round_high: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_ZLH_RND) |=> ACC[15:0] == 16'h8000
            && ACC[31:16] == $past(MEM_DATA))
        else $error("rounded load wrong");
    a_low_unsigned: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_ZHL_U) |=> ACC == {16'h0000, $past(MEM_DATA)})
        else $error("unsigned load wrong");
    a_clear_both: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_CLR_BOTH) |=> ACC == 32'h0000_0000 && PRD == 32'h0000_0000)
        else $error("combined clear wrong");
    a_clear_prd: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_CLR_PRD) |=> PRD == 32'h0000_0000 && $stable(ACC))
        else $error("product clear wrong");
    a_idle_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !OP_VALID && !PRD_LOAD |=> $stable(ACC) && $stable(PRD) && !MEM_WE)
        else $error("state changed while idle");

    // ==========================================================
    // multi-step sequences
    // a high load followed at once by an xor that must see the new word
    sequence s_load_then_xor;
        s_issue(ACZ_OP_ZLH) ##1 s_issue(ACZ_OP_XOR);
    endsequence

    // a mask write-back issue followed by a cycle without one
    sequence s_mem_then_other;
        s_issue(ACZ_OP_XOR_MEM) ##1 !(OP_VALID && OP == ACZ_OP_XOR_MEM);
    endsequence

    // ==========================================================
    // operand and load checks
    a_xor_port_operand: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_XOR) |=> ACC == ($past(ACC) ^ ({16'h0000, ($past(USE_IMM)
            ? $past(IMM_DATA) : $past(MEM_DATA))} << $past(SHIFT))))
        else $error("xor operand not taken from the selected port");

    a_load_then_xor: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_load_then_xor |=> ACC == ({$past(MEM_DATA, 2), 16'h0000}
            ^ ({16'h0000, $past(opnd.value)} << $past(SHIFT))))
        else $error("xor did not see the loaded word");

    a_round_bits: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_ZLH_RND) |=> ACC[RND_BIT] && ACC[RND_BIT-1:0] == 15'h0)
        else $error("rounding bits wrong");

    a_zhl_high_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_ZHL_U) |=> ACC[31:16] == 16'h0000)
        else $error("high half not zeroed");

    // ==========================================================
    // write-back, product and refusal checks
    a_mem_we_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_mem_then_other |=> !MEM_WE)
        else $error("write strobe stood too long");

    a_we_only_mem: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !(OP_VALID && OP == ACZ_OP_XOR_MEM) |=> !MEM_WE)
        else $error("write strobe without mask operation");

    a_prd_load_take: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        PRD_LOAD && !(OP_VALID && (OP == ACZ_OP_CLR_BOTH || OP == ACZ_OP_CLR_PRD))
            |=> PRD == $past(PRD_IN))
        else $error("product load lost");

    a_none_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_issue(ACZ_OP_NONE) |=> $stable(ACC) && !MEM_WE)
        else $error("empty operation changed the accumulator");

    a_bad_code_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        OP_VALID && !$onehot(OP) |=> $stable(ACC) && !MEM_WE)
        else $error("illegal code changed state");

    a_acc_only_on_op: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !OP_VALID |=> $stable(ACC))
        else $error("accumulator moved without an operation");

    // ==========================================================
    // reset values, checked once reset has stood for a full cycle
    a_reset_values: assert property (@(posedge SYS_CLK)
        !RST_N ##1 !RST_N |-> ACC == ACC_RST && PRD == PRD_RST && !MEM_WE
            && MEM_WDATA == MEM_RST)
        else $error("outputs not at reset values");
endmodule

/* File: dv/test_acz_datapath.sv */
// Purpose: self-checking bench for the accumulator logic and zero-load datapath
// Assumes: results show one cycle after the op edge
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module test_acz_datapath;
    import acz_pkg::*;
    logic        SYS_CLK = 0;
    logic        RST_N = 0;
    acz_op_e     OP = ACZ_OP_NONE;
    logic        OP_VALID = 0, USE_IMM = 0, PRD_LOAD = 0;
    logic [15:0] MEM_DATA = '0, IMM_DATA = '0, BIT_MASK = '0, MEM_WDATA;
    logic [3:0]  SHIFT = '0;
    logic [31:0] SEC_ACC = '0, PRD_IN = '0, ACC, PRD;
    logic        MEM_WE;
    int          err_total = 0, samples_checked = 0, cyc = 0;
    acz_datapath dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .OP(OP), .OP_VALID(OP_VALID),
        .MEM_DATA(MEM_DATA), .IMM_DATA(IMM_DATA), .USE_IMM(USE_IMM), .SHIFT(SHIFT),
        .BIT_MASK(BIT_MASK), .SEC_ACC(SEC_ACC), .PRD_LOAD(PRD_LOAD), .PRD_IN(PRD_IN),
        .ACC(ACC), .PRD(PRD), .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE));
    // ==========================================
    // clock, timeout and shared tasks
    initial forever #4 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            err_total++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // issue one op at a falling edge; ops called in a row go back to back
    task automatic run(input acz_op_e o, input logic [15:0] m, input logic [15:0] i,
                       input logic u, input logic [3:0] s);
        OP = o;
        MEM_DATA = m;
        IMM_DATA = i;
        USE_IMM = u;
        SHIFT = s;
        OP_VALID = 1;
        @(negedge SYS_CLK);
    endtask
    task automatic idle;
        OP_VALID = 0;
        @(negedge SYS_CLK);
    endtask
    // ==========================================
    // scenarios
    task automatic t_loads;
        run(ACZ_OP_ZLH, 16'h1234, 16'h0000, 0, 4'h0);
        chk(ACC, 32'h1234_0000);
        run(ACZ_OP_ZLH_RND, 16'hABCD, 16'h0000, 0, 4'h0);
        chk(ACC, 32'hABCD_8000);
        run(ACZ_OP_ZHL_U, 16'h8001, 16'h0000, 0, 4'h0);
        chk(ACC, 32'h0000_8001);
        idle;
        $display("test loads done");
    endtask
    task automatic t_xor;
        SEC_ACC = 32'h0F0F_0F0F;
        run(ACZ_OP_ZLH, 16'hFFFF, 16'h0000, 0, 4'h0);
        run(ACZ_OP_XOR, 16'h0F0F, 16'h0000, 0, 4'h0);
        chk(ACC, 32'hFFFF_0F0F);
        run(ACZ_OP_XOR, 16'h0000, 16'h8001, 1, 4'hF);
        chk(ACC, 32'hBFFF_8F0F);
        run(ACZ_OP_XOR_SEC, 16'h0000, 16'h0000, 0, 4'h0);
        chk(ACC, 32'hB0F0_8000);
        idle;
        chk(ACC, 32'hB0F0_8000);
        $display("test xor done");
    endtask
    task automatic t_mem;
        BIT_MASK = 16'h00FF;
        run(ACZ_OP_XOR_MEM, 16'h1234, 16'hF000, 0, 4'h0);
        chk(32'(MEM_WDATA), 32'h0000_12CB);
        chk(32'(MEM_WE), 32'h1);
        run(ACZ_OP_XOR_MEM, 16'h1234, 16'hF000, 1, 4'h0);
        chk(32'(MEM_WDATA), 32'h0000_E234);
        run(acz_op_e'(10'h00A), 16'h1234, 16'hF000, 1, 4'h0);
        chk(32'(MEM_WE), 32'h0);
        chk(ACC, 32'hB0F0_8000);
        idle;
        chk(32'(MEM_WE), 32'h0);
        chk(ACC, 32'hB0F0_8000);
        $display("test memory xor done");
    endtask
    task automatic t_clear;
        PRD_LOAD = 1;
        PRD_IN = 32'h1357_9BDF;
        run(ACZ_OP_NONE, 16'hFFFF, 16'h0000, 0, 4'h0);
        chk(PRD, 32'h1357_9BDF);
        chk(ACC, 32'hB0F0_8000);
        run(ACZ_OP_CLR_PRD, 16'h0000, 16'h0000, 0, 4'h0);
        chk(PRD, 32'h0000_0000);
        chk(ACC, 32'hB0F0_8000);
        run(ACZ_OP_CLR_ACC, 16'h0000, 16'h0000, 0, 4'h0);
        chk(ACC, 32'h0000_0000);
        run(ACZ_OP_ZLH, 16'h5555, 16'h0000, 0, 4'h0);
        run(ACZ_OP_CLR_BOTH, 16'h0000, 16'h0000, 0, 4'h0);
        chk(ACC, 32'h0000_0000);
        chk(PRD, 32'h0000_0000);
        PRD_LOAD = 0;
        idle;
        $display("test clear done");
    endtask
    task automatic t_reset;
        PRD_LOAD = 1;
        PRD_IN = 32'h2468_ACE0;
        run(ACZ_OP_ZLH, 16'h7E7E, 16'h0000, 0, 4'h0);
        PRD_LOAD = 0;
        run(ACZ_OP_XOR_MEM, 16'hA5A5, 16'h0000, 0, 4'h0);
        chk(32'(MEM_WE), 32'h1);
        RST_N = 0;
        OP_VALID = 0;
        #1;
        chk(ACC, 32'h0000_0000);
        chk(PRD, 32'h0000_0000);
        chk(32'(MEM_WE), 32'h0);
        chk(32'(MEM_WDATA), 32'h0000_0000);
        @(negedge SYS_CLK);
        idle;
        RST_N = 1;
        run(ACZ_OP_ZHL_U, 16'h00C3, 16'h0000, 0, 4'h0);
        chk(ACC, 32'h0000_00C3);
        idle;
        $display("test reset done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        RST_N = 1;
        chk(ACC, 32'h0000_0000);
        t_loads;
        t_xor;
        t_mem;
        t_clear;
        t_reset;
        finish_test;
    end
endmodule
